// ---- rtl/dhi_pkg.sv ----
// shared constants, mode decode and timing for the display host interface
package dhi_pkg;

   // clock rate used to turn times into cycle counts
   localparam int CLK_MHZ = 250;

   // host port modes picked by the three select straps
   typedef enum logic [2:0] {
      DHI_M_NONE = 3'h0,
      DHI_M_6800 = 3'h1,
      DHI_M_8080 = 3'h3,
      DHI_M_SPI4 = 3'h2,
      DHI_M_SPI3 = 3'h6,
      DHI_M_I2C = 3'h7
   } dhi_mode_e;

   // strap values {strap_2, strap_1, strap_0}
   localparam logic [2:0] STRAP_6800 = 3'h4;
   localparam logic [2:0] STRAP_8080 = 3'h6;
   localparam logic [2:0] STRAP_SPI4 = 3'h0;
   localparam logic [2:0] STRAP_SPI3 = 3'h1;
   localparam logic [2:0] STRAP_I2C = 3'h2;

   // widths of the link data and of a buffered write word {is_data, byte}
   localparam int DATA_W = 8;
   localparam int WORD_W = 9;
   localparam int BUF_DEPTH = 2;

   // reset values
   localparam logic [3:0] CTL_IDLE = 4'hf; // {cs_n, cmd_data_select, rd/e, wr/rw}
   localparam logic [7:0] BUS_IDLE = 8'hff; // pulled-up bus when nobody drives
   localparam logic [2:0] SER_LAST_BIT = 3'h7;

   // host timing, in ns as chosen, and the derived cycle counts
   localparam int T_SETUP_NS = 40;
   localparam int T_STROBE_NS = 100;
   localparam int T_HOLD_NS = 40;
   localparam int T_SCLK_HALF_NS = 64;

   // least time rounded up to whole cycles, never below one
   function automatic int ns_to_cyc_min(input int ns);
      int c;
      c = (ns * CLK_MHZ + 999) / 1000;
      return (c < 1) ? 1 : c;
   endfunction : ns_to_cyc_min

   localparam logic [7:0] SETUP_CYC = 8'(ns_to_cyc_min(T_SETUP_NS));
   localparam logic [7:0] STROBE_CYC = 8'(ns_to_cyc_min(T_STROBE_NS));
   localparam logic [7:0] HOLD_CYC = 8'(ns_to_cyc_min(T_HOLD_NS));
   localparam logic [7:0] SCLK_HALF_CYC = 8'(ns_to_cyc_min(T_SCLK_HALF_NS));

   // straps to port mode
   function automatic dhi_mode_e mode_decode(input logic [2:0] straps);
      case (straps)
         STRAP_6800: return DHI_M_6800;
         STRAP_8080: return DHI_M_8080;
         STRAP_SPI4: return DHI_M_SPI4;
         STRAP_SPI3: return DHI_M_SPI3;
         STRAP_I2C: return DHI_M_I2C;
         default: return DHI_M_NONE;
      endcase
   endfunction : mode_decode

endpackage : dhi_pkg

// ---- rtl/dhi_if.sv ----
// pin-level link between host and display device
`timescale 1ns/1ps
interface dhi_if;
   logic port_select_strap_0; // strap, board level
   logic port_select_strap_1; // strap, board level
   logic port_select_strap_2; // strap, board level
   logic cs_n; // chip select, low active
   logic cmd_data_select; // high data, low command/status
   logic rd_e; // 6800 enable or 8080 read strobe (low)
   logic wr_rw; // 6800 read/write or 8080 write strobe (low)
   logic [7:0] host_dout; // host data out (serial: bit0 clock, bit1 data)
   logic host_oe; // host drives data pads
   logic [7:0] dev_dout; // device data out
   logic dev_oe; // device drives data pads
   logic [7:0] bus; // resolved pad level

   // resolved pad level, pulled up when idle
   assign bus = dev_oe ? dev_dout : (host_oe ? host_dout : dhi_pkg::BUS_IDLE);

   modport device (
      input port_select_strap_0, port_select_strap_1, port_select_strap_2,
      input cs_n, cmd_data_select, rd_e, wr_rw, bus,
      output dev_dout, dev_oe
   );
   modport host (
      output port_select_strap_0, port_select_strap_1, port_select_strap_2,
      output cs_n, cmd_data_select, rd_e, wr_rw, host_dout, host_oe,
      input bus
   );
endinterface : dhi_if

// ---- rtl/dhi_buf.sv ----
// two-entry write buffer with valid/ready on both sides
`timescale 1ns/1ps
module dhi_buf (
   input wire logic clk, // system clock
   input wire logic srst, // sync reset, high
   input wire logic ce, // clock enable
   input wire logic in_valid, // word offered
   output logic in_ready, // room for a word
   input wire logic [dhi_pkg::WORD_W-1:0] in_word, // word in
   output logic out_valid, // head word valid
   input wire logic out_ready, // consumer takes head
   output logic [dhi_pkg::WORD_W-1:0] out_word // head word
);
   typedef struct packed {
      logic [dhi_pkg::BUF_DEPTH-1:0] v;
      logic [dhi_pkg::BUF_DEPTH-1:0][dhi_pkg::WORD_W-1:0] d;
   } dhi_buf_s;

   dhi_buf_s q_reg, q_next;

   assign in_ready = ~q_reg.v[1];
   assign out_valid = q_reg.v[0];
   assign out_word = q_reg.d[0];

   // head shifts on pop, push lands in the first free slot
   always_comb begin
      q_next = q_reg;
      if (q_reg.v[0] && out_ready) begin
         q_next.d[0] = q_reg.d[1];
         q_next.v[0] = q_reg.v[1];
         q_next.v[1] = 1'b0;
      end
      if (in_valid && !q_reg.v[1]) begin
         if (!q_next.v[0]) begin
            q_next.d[0] = in_word;
            q_next.v[0] = 1'b1;
         end else begin
            q_next.d[1] = in_word;
            q_next.v[1] = 1'b1;
         end
      end
   end

   // register
   always_ff @(posedge clk) begin
      if (srst) begin
         q_reg <= '0;
      end else if (ce) begin
         q_reg <= q_next;
      end
   end
endmodule : dhi_buf

// ---- rtl/dhi_device.sv ----
// display-side end of the host port: parallel 6800/8080 and 4-wire serial
//
// Summary of operation
// - straps select 6800, 8080, serial, I2C modes
// - 6800: direction high reads, low writes
// - 6800: enable high latches only with select low
// - RAM reads pipelined; first read is dummy
// - 8080: low read strobe reads data/status
// - 8080: low write strobe writes data/command
// - host issues dummy read in 8080 too
// - select plus direction decode four cycle kinds
// - serial: shift eight bits MSB first, rising clock
// - eighth clock samples select, writes byte
// - select high holds serial port initialised
// - select falling edge starts serial transfer
// - select may stay low; toggling preferred
// - deselect clears shift register and counter
// - serial mode supports writes only
// - host holds unused strobes fixed in serial
// - parallel: byte per cycle, drive on reads
`timescale 1ns/1ps
module dhi_device (
   input wire logic clk, // system clock
   input wire logic srst, // sync reset, high
   input wire logic ce, // clock enable, freezes state when low
   dhi_if.device link, // host pins
   input wire logic [7:0] status_in, // status byte for status reads
   input wire logic [7:0] ram_rd_data, // RAM byte, valid cycle after request
   output logic ram_rd_req, // pulse: fetch next RAM byte
   output logic wr_valid, // write word waiting
   input wire logic wr_ready, // consumer takes write word
   output logic wr_is_data, // 1 RAM data, 0 command
   output logic [7:0] wr_byte, // written byte
   output logic port_busy // write still pending, host must wait
);
   typedef struct packed {
      logic [2:0] strap_s1;
      logic [2:0] strap_s2;
      logic [3:0] ctl_s1;
      logic [3:0] ctl_s2;
      logic [7:0] bus_s1;
      logic [7:0] bus_s2;
      logic rd_act;
      logic wr_act;
      logic rd_is_data;
      logic [7:0] dout;
      logic oe;
      logic [7:0] pipe;
      logic fetch_req;
      logic fetch_pend;
      logic [7:0] wr_hold;
      logic cds_hold;
      logic sclk_q;
      logic [7:0] sr;
      logic [2:0] bitcnt;
      logic pend;
      logic [8:0] pend_word;
      logic busy;
   } dhi_dev_s;

   dhi_dev_s q_reg, q_next;
   dhi_pkg::dhi_mode_e mode;
   logic cs_low;
   logic cds;
   logic rde;
   logic wrrw;
   logic rd_now;
   logic wr_now;
   logic push_req;
   logic [8:0] push_word;
   logic buf_in_ready;
   logic [8:0] buf_out;
   logic buf_out_valid;

   // pad outputs and user side straight from flops
   assign link.dev_dout = q_reg.dout;
   assign link.dev_oe = q_reg.oe;
   assign ram_rd_req = q_reg.fetch_req;
   assign port_busy = q_reg.busy;

   // decoded view of the synchronised pins
   always_comb begin
      mode = dhi_pkg::mode_decode(q_reg.strap_s2);
      cs_low = ~q_reg.ctl_s2[3];
      cds = q_reg.ctl_s2[2];
      rde = q_reg.ctl_s2[1];
      wrrw = q_reg.ctl_s2[0];
      case (mode)
         dhi_pkg::DHI_M_6800: begin
            rd_now = cs_low & rde & wrrw;
            wr_now = cs_low & rde & ~wrrw;
         end
         dhi_pkg::DHI_M_8080: begin
            rd_now = cs_low & ~rde;
            wr_now = cs_low & ~wrrw;
         end
         default: begin
            rd_now = 1'b0;
            wr_now = 1'b0;
         end
      endcase
   end

   // next state
   always_comb begin
      q_next = q_reg;
      push_req = 1'b0;
      push_word = '0;
      q_next.fetch_req = 1'b0;
      // two flops on every pin before use
      q_next.strap_s1 = {link.port_select_strap_2, link.port_select_strap_1,
                         link.port_select_strap_0};
      q_next.strap_s2 = q_reg.strap_s1;
      q_next.ctl_s1 = {link.cs_n, link.cmd_data_select, link.rd_e, link.wr_rw};
      q_next.ctl_s2 = q_reg.ctl_s1;
      q_next.bus_s1 = link.bus;
      q_next.bus_s2 = q_reg.bus_s1;
      q_next.rd_act = rd_now;
      q_next.wr_act = wr_now;

      // read start: pick pipelined RAM byte or status
      if (rd_now && !q_reg.rd_act) begin
         q_next.dout = cds ? q_reg.pipe : status_in;
         q_next.rd_is_data = cds;
      end
      q_next.oe = rd_now;
      // data read end refills the pipe, so the first read returns stale data
      if (!rd_now && q_reg.rd_act && q_reg.rd_is_data) begin
         q_next.fetch_req = 1'b1;
      end
      q_next.fetch_pend = q_reg.fetch_req;
      if (q_reg.fetch_pend) begin
         q_next.pipe = ram_rd_data;
      end

      // parallel write: keep the last sampled byte, commit at strobe end
      if (wr_now) begin
         q_next.wr_hold = q_reg.bus_s2;
         q_next.cds_hold = cds;
      end
      if (!wr_now && q_reg.wr_act) begin
         push_req = 1'b1;
         push_word = {q_reg.cds_hold, q_reg.wr_hold};
      end

      // 4-wire serial: bus bit0 is the clock, bit1 the data
      q_next.sclk_q = q_reg.bus_s2[0];
      if (mode == dhi_pkg::DHI_M_SPI4) begin
         if (!cs_low) begin
            // held clear while deselected, so a falling select starts at bit 0
            q_next.sr = '0;
            q_next.bitcnt = '0;
         end else if (q_reg.bus_s2[0] && !q_reg.sclk_q) begin
            q_next.sr = {q_reg.sr[6:0], q_reg.bus_s2[1]};
            q_next.bitcnt = 3'(q_reg.bitcnt + 3'h1);
            if (q_reg.bitcnt == dhi_pkg::SER_LAST_BIT) begin
               push_req = 1'b1;
               push_word = {cds, q_reg.sr[6:0], q_reg.bus_s2[1]};
            end
         end
      end

      // one holding slot ahead of the buffer; busy while it is full
      if (push_req) begin
         q_next.pend = 1'b1;
         q_next.pend_word = push_word;
      end else if (q_reg.pend && buf_in_ready) begin
         q_next.pend = 1'b0;
      end
      q_next.busy = q_next.pend;
   end

   // register, control pin syncs reset to their idle levels, strap and bus syncs to zero
   always_ff @(posedge clk) begin
      if (srst) begin
         q_reg <= '0;
         q_reg.ctl_s1 <= dhi_pkg::CTL_IDLE;
         q_reg.ctl_s2 <= dhi_pkg::CTL_IDLE;
      end else if (ce) begin
         q_reg <= q_next;
      end
   end

   // a stalled consumer backs up here and then raises port_busy
   dhi_buf u_buf (
      .clk(clk),
      .srst(srst),
      .ce(ce),
      .in_valid(q_reg.pend),
      .in_ready(buf_in_ready),
      .in_word(q_reg.pend_word),
      .out_valid(buf_out_valid),
      .out_ready(wr_ready),
      .out_word(buf_out)
   );

   assign wr_valid = buf_out_valid;
   assign wr_is_data = buf_out[8];
   assign wr_byte = buf_out[7:0];
endmodule : dhi_device

// ---- rtl/dhi_host.sv ----
// host-side end: drives 6800, 8080 or 4-wire serial cycles from commands
`timescale 1ns/1ps
module dhi_host (
   input wire logic clk, // system clock
   input wire logic srst, // sync reset, high
   input wire logic ce, // clock enable, freezes state when low
   dhi_if.host link, // device pins
   input wire logic [2:0] strap_sel, // {strap_2, strap_1, strap_0}
   input wire logic cmd_valid, // command offered
   output logic cmd_ready, // host idle, takes command
   input wire logic cmd_is_read, // 1 read, 0 write
   input wire logic cmd_is_data, // 1 RAM data, 0 command/status
   input wire logic [7:0] cmd_wdata, // write byte
   output logic rsp_valid, // pulse: read byte ready
   output logic [7:0] rsp_data // read byte
);
   typedef enum logic [2:0] {
      H_IDLE = 3'h0,
      H_SETUP = 3'h1,
      H_STROBE = 3'h3,
      H_HOLD = 3'h2,
      H_SCK_LO = 3'h6,
      H_SCK_HI = 3'h7
   } dhi_hst_e;

   typedef struct packed {
      dhi_hst_e state;
      logic [7:0] cnt;
      logic [2:0] bitn;
      logic [7:0] sh;
      logic is_read;
      logic [2:0] straps;
      logic cs_n;
      logic cds;
      logic rd_e;
      logic wr_rw;
      logic [7:0] dout;
      logic oe;
      logic [7:0] bus_s1;
      logic [7:0] bus_s2;
      logic rdy;
      logic rsp_v;
      logic [7:0] rsp_d;
   } dhi_hst_s;

   dhi_hst_s q_reg, q_next;
   dhi_pkg::dhi_mode_e mode;
   logic is_spi;
   logic is_6800;

   assign link.port_select_strap_0 = q_reg.straps[0];
   assign link.port_select_strap_1 = q_reg.straps[1];
   assign link.port_select_strap_2 = q_reg.straps[2];
   assign link.cs_n = q_reg.cs_n;
   assign link.cmd_data_select = q_reg.cds;
   assign link.rd_e = q_reg.rd_e;
   assign link.wr_rw = q_reg.wr_rw;
   assign link.host_dout = q_reg.dout;
   assign link.host_oe = q_reg.oe;
   assign cmd_ready = q_reg.rdy;
   assign rsp_valid = q_reg.rsp_v;
   assign rsp_data = q_reg.rsp_d;

   // next state; strobe timing counted in system clocks
   always_comb begin
      mode = dhi_pkg::mode_decode(q_reg.straps);
      is_spi = (mode == dhi_pkg::DHI_M_SPI4);
      is_6800 = (mode == dhi_pkg::DHI_M_6800);
      q_next = q_reg;
      q_next.straps = strap_sel;
      q_next.bus_s1 = link.bus;
      q_next.bus_s2 = q_reg.bus_s1;
      q_next.rsp_v = 1'b0;
      q_next.cnt = 8'(q_reg.cnt - 8'h01);
      case (q_reg.state)
         H_IDLE: begin
            // idle levels; unused strobes held high in serial mode
            q_next.cs_n = 1'b1;
            q_next.rd_e = is_6800 ? 1'b0 : 1'b1;
            q_next.wr_rw = 1'b1;
            q_next.oe = 1'b0;
            if (cmd_valid && q_reg.rdy) begin
               q_next.is_read = cmd_is_read;
               q_next.cds = cmd_is_data;
               q_next.sh = cmd_wdata;
               q_next.cnt = 8'(dhi_pkg::SETUP_CYC - 8'h01);
               q_next.bitn = '0;
               if (is_spi) begin
                  // reads cannot be done serially and are dropped
                  if (!cmd_is_read) begin
                     q_next.cs_n = 1'b0;
                     q_next.oe = 1'b1;
                     q_next.dout = {6'h00, cmd_wdata[7], 1'b0};
                     q_next.state = H_SETUP;
                  end
               end else begin
                  q_next.cs_n = 1'b0;
                  q_next.wr_rw = is_6800 ? cmd_is_read : 1'b1;
                  q_next.dout = cmd_wdata;
                  q_next.oe = ~cmd_is_read;
                  q_next.state = H_SETUP;
               end
            end
         end
         H_SETUP: begin
            if (q_reg.cnt == 8'h00) begin
               if (is_spi) begin
                  q_next.dout[0] = 1'b1;
                  q_next.cnt = 8'(dhi_pkg::SCLK_HALF_CYC - 8'h01);
                  q_next.state = H_SCK_HI;
               end else begin
                  if (is_6800) begin
                     q_next.rd_e = 1'b1;
                  end else if (q_reg.is_read) begin
                     q_next.rd_e = 1'b0;
                  end else begin
                     q_next.wr_rw = 1'b0;
                  end
                  q_next.cnt = 8'(dhi_pkg::STROBE_CYC - 8'h01);
                  q_next.state = H_STROBE;
               end
            end
         end
         H_STROBE: begin
            if (q_reg.cnt == 8'h00) begin
               q_next.rsp_d = q_reg.bus_s2;
               q_next.rd_e = is_6800 ? 1'b0 : 1'b1;
               q_next.wr_rw = is_6800 ? q_reg.wr_rw : 1'b1;
               q_next.cnt = 8'(dhi_pkg::HOLD_CYC - 8'h01);
               q_next.state = H_HOLD;
            end
         end
         H_SCK_HI: begin
            if (q_reg.cnt == 8'h00) begin
               q_next.dout[0] = 1'b0;
               q_next.cnt = 8'(dhi_pkg::SCLK_HALF_CYC - 8'h01);
               if (q_reg.bitn == dhi_pkg::SER_LAST_BIT) begin
                  q_next.cnt = 8'(dhi_pkg::HOLD_CYC - 8'h01);
                  q_next.state = H_HOLD;
               end else begin
                  q_next.bitn = 3'(q_reg.bitn + 3'h1);
                  q_next.sh = {q_reg.sh[6:0], 1'b0};
                  q_next.dout[1] = q_reg.sh[6];
                  q_next.state = H_SCK_LO;
               end
            end
         end
         H_SCK_LO: begin
            if (q_reg.cnt == 8'h00) begin
               q_next.dout[0] = 1'b1;
               q_next.cnt = 8'(dhi_pkg::SCLK_HALF_CYC - 8'h01);
               q_next.state = H_SCK_HI;
            end
         end
         H_HOLD: begin
            if (q_reg.cnt == 8'h00) begin
               q_next.cs_n = 1'b1;
               q_next.oe = 1'b0;
               q_next.rsp_v = q_reg.is_read;
               q_next.state = H_IDLE;
            end
         end
         default: begin
            q_next.state = H_IDLE;
         end
      endcase
      q_next.rdy = (q_next.state == H_IDLE);
   end

   // register, pins parked idle
   always_ff @(posedge clk) begin
      if (srst) begin
         q_reg <= '0;
         q_reg.cs_n <= 1'b1;
         q_reg.wr_rw <= 1'b1;
         q_reg.rd_e <= 1'b1;
      end else if (ce) begin
         q_reg <= q_next;
      end
   end
endmodule : dhi_host

// ---- testbench/dhi_properties.sv ----
// pin-level checks on the link joining host end and device end
`timescale 1ns/1ps
module dhi_properties (
   input wire logic clk, // system clock
   input wire logic srst, // sync reset, high
   input wire logic port_select_strap_0, // strap 0
   input wire logic port_select_strap_1, // strap 1
   input wire logic port_select_strap_2, // strap 2
   input wire logic cs_n, // chip select, low
   input wire logic rd_e, // enable or read strobe
   input wire logic wr_rw, // direction or write strobe
   input wire logic [7:0] host_dout, // host pad data
   input wire logic host_oe, // host drives pads
   input wire logic dev_oe // device drives pads
);
   logic [2:0] straps;
   logic m80;
   logic m68;
   logic mser;
   // own strap decode, not the design's function
   assign straps = {port_select_strap_2, port_select_strap_1, port_select_strap_0};
   assign m80 = (straps == 3'h6);
   assign m68 = (straps == 3'h4);
   assign mser = (straps == 3'h0);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // depth 4 leaves room for the device's release lag
   a_pads_released: assert property (cs_n [*4] |-> !dev_oe)
      else $error("device drives pads while deselected");
   a_no_contention: assert property (!(dev_oe && host_oe))
      else $error("both ends drive the pads");
   a_serial_quiet: assert property (mser |-> !dev_oe)
      else $error("device drives pads in serial mode");
   a_read_8080: assert property ((m80 && !cs_n && !rd_e) [*5] |-> dev_oe)
      else $error("no read data on pads in 8080 mode");
   a_read_6800: assert property ((m68 && !cs_n && rd_e && wr_rw) [*5] |-> dev_oe)
      else $error("no read data on pads in 6800 mode");
   a_write_quiet: assert property ((m80 && !cs_n && !wr_rw) [*5] |-> !dev_oe)
      else $error("device drives pads during a write");
   a_serial_strobes: assert property (mser && !cs_n |-> rd_e && wr_rw)
      else $error("strobe moved during a serial frame");
   a_strobe_framed: assert property (m80 && (!rd_e || !wr_rw) |-> !cs_n)
      else $error("strobe active while deselected");
   a_data_stable: assert property (m80 && !wr_rw && !$past(wr_rw) |-> $stable(host_dout))
      else $error("write data moved under the strobe");
endmodule : dhi_properties

// ---- testbench/testbench.sv ----
// self-checking bench: host end talks to device end across the pin link
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [2:0] strap_sel = 3'h0;
   logic cmd_valid = 1'b0;
   logic cmd_ready;
   logic cmd_is_read = 1'b0;
   logic cmd_is_data = 1'b0;
   logic [7:0] cmd_wdata = 8'h00;
   logic rsp_valid;
   logic [7:0] rsp_data;
   logic [7:0] status_in = 8'h00;
   logic [7:0] ram_rd_data = 8'h00;
   logic ram_rd_req;
   logic wr_valid;
   logic wr_ready = 1'b1;
   logic wr_is_data;
   logic [7:0] wr_byte;
   logic port_busy;
   logic [8:0] wq[$];
   logic [7:0] rq[$];
   logic [7:0] pipe_exp = 8'h00;
   int n_fetch = 0;
   int n_errors = 0;
   int check_count = 0;

   dhi_if link ();
   dhi_host dhi_host_i (.clk, .srst, .ce(1'b1), .link(link.host), .strap_sel, .cmd_valid,
      .cmd_ready, .cmd_is_read, .cmd_is_data, .cmd_wdata, .rsp_valid, .rsp_data);
   dhi_device dhi_device_i (.clk, .srst, .ce(1'b1), .link(link.device), .status_in,
      .ram_rd_data, .ram_rd_req, .wr_valid, .wr_ready, .wr_is_data, .wr_byte, .port_busy);
   dhi_properties dhi_properties_i (.clk, .srst,
      .port_select_strap_0(link.port_select_strap_0),
      .port_select_strap_1(link.port_select_strap_1),
      .port_select_strap_2(link.port_select_strap_2), .cs_n(link.cs_n), .rd_e(link.rd_e),
      .wr_rw(link.wr_rw), .host_dout(link.host_dout), .host_oe(link.host_oe),
      .dev_oe(link.dev_oe));

   always #2 clk = ~clk;

   // collect write words, read bytes and RAM fetches as they leave the ends
   always @(posedge clk) begin
      if (wr_valid === 1'b1 && wr_ready === 1'b1) wq.push_back({wr_is_data, wr_byte});
      if (rsp_valid === 1'b1) rq.push_back(rsp_data);
      if (ram_rd_req === 1'b1) n_fetch++;
   end

   task automatic check_val(input logic [8:0] got, input logic [8:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_val

   // one command, held until taken, then wait for the host to go idle
   task automatic do_cmd(input logic rd, input logic dat, input logic [7:0] wd);
      int i;
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_is_read = rd;
      cmd_is_data = dat;
      cmd_wdata = wd;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (cmd_ready !== 1'b1 && i < 400);
      @(negedge clk);
      cmd_valid = 1'b0;
      while (cmd_ready !== 1'b1 && i < 800) begin
         @(negedge clk);
         i++;
      end
      if (i >= 800) check_val(9'h000, 9'h1ff);
   endtask : do_cmd

   task automatic pop_word(input logic [8:0] exp);
      int i;
      i = 0;
      while (wq.size() == 0 && i < 100) begin
         @(negedge clk);
         i++;
      end
      check_val((wq.size() != 0) ? wq.pop_front() : 9'h1ff, exp);
   endtask : pop_word

   task automatic read_chk(input logic dat, input logic [7:0] exp);
      int i;
      do_cmd(1'b1, dat, 8'h00);
      i = 0;
      while (rq.size() == 0 && i < 20) begin
         @(negedge clk);
         i++;
      end
      check_val({1'b0, (rq.size() != 0) ? rq.pop_front() : 8'hxx}, {1'b0, exp});
   endtask : read_chk

   // straps pass a sync on the device side, so give them time
   task automatic set_mode(input logic [2:0] s);
      strap_sel = s;
      repeat (6) @(negedge clk);
   endtask : set_mode

   task automatic test_par(input logic [2:0] s, input logic [7:0] v);
      int f0;
      set_mode(s);
      do_cmd(1'b0, 1'b0, v);
      pop_word({1'b0, v});
      do_cmd(1'b0, 1'b1, ~v);
      pop_word({1'b1, ~v});
      status_in = v ^ 8'h0f;
      f0 = n_fetch;
      read_chk(1'b0, v ^ 8'h0f);
      check_val(9'(n_fetch - f0), 9'h000);
      // data reads lag one fetch behind: first one returns the old pipe byte
      for (int k = 1; k < 3; k++) begin
         ram_rd_data = v + 8'(k);
         read_chk(1'b1, pipe_exp);
         pipe_exp = v + 8'(k);
      end
      check_val(9'(n_fetch - f0), 9'h002);
      $display("test_par mode %h done", s);
   endtask : test_par

   // consumer stalls: two buffer entries plus the holding slot lose nothing
   task automatic test_stall();
      wr_ready = 1'b0;
      for (int k = 0; k < 3; k++) do_cmd(1'b0, 1'b1, 8'h40 + 8'(k));
      check_val({8'h00, port_busy}, 9'h001);
      check_val(9'(wq.size()), 9'h000);
      wr_ready = 1'b1;
      for (int k = 0; k < 3; k++) pop_word({1'b1, 8'h40 + 8'(k)});
      check_val({8'h00, port_busy}, 9'h000);
      $display("test_stall done");
   endtask : test_stall

   task automatic test_serial();
      int f0;
      set_mode(3'h0);
      do_cmd(1'b0, 1'b0, 8'ha5);
      pop_word({1'b0, 8'ha5});
      do_cmd(1'b0, 1'b1, 8'h96);
      pop_word({1'b1, 8'h96});
      f0 = n_fetch;
      do_cmd(1'b1, 1'b1, 8'h00);
      repeat (60) @(negedge clk);
      check_val(9'(rq.size() + wq.size() + n_fetch - f0), 9'h000);
      // three-wire and bus-pair straps leave this port deaf
      set_mode(3'h1);
      do_cmd(1'b0, 1'b1, 8'h33);
      set_mode(3'h2);
      do_cmd(1'b0, 1'b1, 8'h44);
      repeat (20) @(negedge clk);
      check_val(9'(wq.size()), 9'h000);
      $display("test_serial done");
   endtask : test_serial

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : finish_test

   // main sequence
   initial begin
      repeat (12) @(negedge clk);
      srst = 1'b0;
      repeat (4) @(negedge clk);
      test_par(3'h6, 8'h3c);
      test_stall();
      test_par(3'h4, 8'h96);
      test_serial();
      finish_test();
   end

   // watchdog, far beyond the roughly 1400 cycles the tests need
   initial begin
      #100000;
      n_errors++;
      finish_test();
   end
endmodule : testbench
